/* pkg/timer_two_pkg.sv */
package timer_two_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;

   // Register offsets in special-function space.
   localparam logic [7:0] OFF_CONTROL = 8'hC8;
   localparam logic [7:0] OFF_MODE = 8'hC9;
   localparam logic [7:0] OFF_RCMP_LO = 8'hCA;
   localparam logic [7:0] OFF_RCMP_HI = 8'hCB;
   localparam logic [7:0] OFF_COUNT_LO = 8'hCC;
   localparam logic [7:0] OFF_COUNT_HI = 8'hCD;
   localparam logic [7:0] OFF_CAP0_LO = 8'hE4;
   localparam logic [7:0] OFF_CAP0_HI = 8'hE5;
   localparam logic [7:0] OFF_CAP1_LO = 8'hE6;
   localparam logic [7:0] OFF_CAP1_HI = 8'hE7;
   localparam logic [7:0] OFF_CAP2_LO = 8'hE8;
   localparam logic [7:0] OFF_CAP2_HI = 8'hE9;

   // Control register fields.
   localparam int CTL_OVF_BIT = 7;
   localparam int CTL_RUN_BIT = 2;
   localparam int CTL_MODE_BIT = 0;

   // Mode register fields.
   localparam int MOD_RELOAD_EN_BIT = 7;
   localparam int MOD_DIV_MSB = 6;
   localparam int MOD_DIV_LSB = 4;
   localparam int MOD_CAP_CLR_BIT = 3;
   localparam int MOD_MATCH_CLR_BIT = 2;
   localparam int MOD_TRIG_MSB = 1;
   localparam int MOD_TRIG_LSB = 0;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   localparam int PRESC_W = 9;

   typedef enum logic [1:0] {
      TRIG_OVERFLOW = 2'b00,
      TRIG_CAPTURE0 = 2'b01,
      TRIG_CAPTURE1 = 2'b10,
      TRIG_CAPTURE2 = 2'b11
   } trigger_t;

   // Prescaler terminal counts (ratio minus one) per divider code.
   function automatic logic [PRESC_W-1:0] div_last(input logic [2:0] code);
      logic [PRESC_W-1:0] r;
      r = 9'h000;
      unique case (code)
         3'b000: r = 9'h000;
         3'b001: r = 9'h003;
         3'b010: r = 9'h00F;
         3'b011: r = 9'h01F;
         3'b100: r = 9'h03F;
         3'b101: r = 9'h07F;
         3'b110: r = 9'h0FF;
         3'b111: r = 9'h1FF;
      endcase
      return r;
   endfunction

endpackage

/* core/timer_two.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - 16-bit up counter from two byte registers.
// - Prescaler divides by 1,4,16,32,64,128,256,512.
// - Counts only while run bit set; otherwise holds except for capture auto-clear or capture-triggered reload.
// - Mode bit 0 reload, 1 compare.
// - Overflow or match sets overflow flag bit 7.
// - Hardware never clears flag; software clears it.
// - Interrupt request when flag, timer and global enables.
// - Reload happens only with reload enable set.
// - Trigger select: overflow or capture channel 0-2.
// - Reload mode capture auto-clear zeroes counter.
// - Compare mode match auto-clear zeroes counter.
// - Reload/compare pair serves as reload or compare.
// - Three capture channels each hold 16-bit value.
// - Control, mode, compare, count reset to zero.
// - Compare mode equality sets overflow flag.
// - Selected reload event loads reload value.
// - With auto-clear, capture only clears, no reload.
// - Capture copies count and sets channel flag.
module timer_two (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [timer_two_pkg::ADDR_W-1:0] addr_i,
   input wire logic [timer_two_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [timer_two_pkg::DATA_W-1:0] rdata_o,
   input wire logic [2:0] capture_event_i,
   input wire logic [2:0] capture_flag_clr_i,
   input wire logic timer_irq_en_i,
   input wire logic global_irq_en_i,
   output logic irq_o,
   output logic [2:0] capture_flag_o
);
   import timer_two_pkg::*;

   logic overflow_flag_reg;
   logic run_bit_reg;
   logic mode_select_bit_reg;
   logic [7:0] mode_register_reg;
   logic [7:0] reload_compare_lo_reg;
   logic [7:0] reload_compare_hi_reg;
   logic [7:0] count_low_reg;
   logic [7:0] count_high_reg;
   logic [15:0] count_value;
   logic [15:0] count_next;
   logic [15:0] capture_reg [3];
   logic [PRESC_W-1:0] presc_reg;
   logic tick;
   logic [15:0] reload_value;
   logic overflow_evt;
   logic match_evt;
   logic any_capture;
   logic reload_evt;
   logic trig_capture;
   logic cap_clear;
   logic [2:0] divider_field;
   trigger_t reload_trigger_select;
   logic reload_enable;
   logic capture_auto_clear;
   logic match_auto_clear;
   logic wr_ctl;
   logic wr_mod;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_rcmp_lo;
   logic wr_rcmp_hi;
   logic [PRESC_W-1:0] presc_last;
   logic reload_now;
   logic match_clear_now;
   logic flag_set;
   logic [7:0] control_view;
   logic [7:0] read_mux;

   assign divider_field = mode_register_reg[MOD_DIV_MSB:MOD_DIV_LSB];
   assign reload_trigger_select = trigger_t'(mode_register_reg[MOD_TRIG_MSB:MOD_TRIG_LSB]);
   assign reload_enable = mode_register_reg[MOD_RELOAD_EN_BIT];
   assign capture_auto_clear = mode_register_reg[MOD_CAP_CLR_BIT];
   assign match_auto_clear = mode_register_reg[MOD_MATCH_CLR_BIT];
   assign reload_value = {reload_compare_hi_reg, reload_compare_lo_reg};

   assign wr_ctl = wr_i && (addr_i == OFF_CONTROL);
   assign wr_mod = wr_i && (addr_i == OFF_MODE);
   assign wr_cnt_lo = wr_i && (addr_i == OFF_COUNT_LO);
   assign wr_cnt_hi = wr_i && (addr_i == OFF_COUNT_HI);
   assign wr_rcmp_lo = wr_i && (addr_i == OFF_RCMP_LO);
   assign wr_rcmp_hi = wr_i && (addr_i == OFF_RCMP_HI);

   assign count_value = {count_high_reg, count_low_reg};
   assign presc_last = div_last(divider_field);

   // Prescaler: held at zero while stopped, restarted whenever it reaches the terminal count (ratio minus one).
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         presc_reg <= '0;
      end else if (!run_bit_reg) begin
         presc_reg <= '0;
      end else if (presc_reg >= presc_last) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 9'h001;
      end
   end

   assign tick = run_bit_reg && (presc_reg >= presc_last);

   assign overflow_evt = tick && (count_value == 16'hFFFF);
   assign match_evt = mode_select_bit_reg && (count_value == reload_value);
   assign any_capture = |capture_event_i;

   always_comb begin
      trig_capture = 1'b0;
      unique case (reload_trigger_select)
         TRIG_OVERFLOW: trig_capture = 1'b0;
         TRIG_CAPTURE0: trig_capture = capture_event_i[0];
         TRIG_CAPTURE1: trig_capture = capture_event_i[1];
         TRIG_CAPTURE2: trig_capture = capture_event_i[2];
      endcase
   end

   assign reload_evt = (reload_trigger_select == TRIG_OVERFLOW) ? overflow_evt : trig_capture;
   assign cap_clear = !mode_select_bit_reg && capture_auto_clear && any_capture;
   assign reload_now = !mode_select_bit_reg && reload_enable && reload_evt;
   assign match_clear_now = mode_select_bit_reg && match_auto_clear && match_evt && tick;
   assign flag_set = overflow_evt || match_evt;

   // Counter next value; clearing and reloading outrank plain counting.
   always_comb begin
      count_next = count_value;
      if (cap_clear) begin
         count_next = RESET_COUNT;
      end else if (reload_now) begin
         count_next = reload_value;
      end else if (match_clear_now) begin
         count_next = RESET_COUNT;
      end else if (tick) begin
         count_next = count_value + 16'h0001;
      end
   end

   // Software writes take the byte they address; the other byte follows hardware.
   // A byte written while the counter runs races the increment, so stop it first.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_low_reg <= RESET_BYTE;
      end else if (wr_cnt_lo) begin
         count_low_reg <= wdata_i;
      end else begin
         count_low_reg <= count_next[7:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_high_reg <= RESET_BYTE;
      end else if (wr_cnt_hi) begin
         count_high_reg <= wdata_i;
      end else begin
         count_high_reg <= count_next[15:8];
      end
   end

   // A hardware set wins over a software clear in the same cycle.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_flag_reg <= 1'b0;
      end else if (flag_set) begin
         overflow_flag_reg <= 1'b1;
      end else if (wr_ctl) begin
         overflow_flag_reg <= wdata_i[CTL_OVF_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_bit_reg <= 1'b0;
         mode_select_bit_reg <= 1'b0;
      end else if (wr_ctl) begin
         run_bit_reg <= wdata_i[CTL_RUN_BIT];
         mode_select_bit_reg <= wdata_i[CTL_MODE_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_register_reg <= RESET_BYTE;
      end else if (wr_mod) begin
         mode_register_reg <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reload_compare_lo_reg <= RESET_BYTE;
      end else if (wr_rcmp_lo) begin
         reload_compare_lo_reg <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reload_compare_hi_reg <= RESET_BYTE;
      end else if (wr_rcmp_hi) begin
         reload_compare_hi_reg <= wdata_i;
      end
   end

   // Capture channels latch the count as it stood before this cycle's update.
   for (genvar ch = 0; ch < 3; ch++) begin : g_cap
      logic cap_wr_lo;
      logic cap_wr_hi;

      assign cap_wr_lo = wr_i && (addr_i == OFF_CAP0_LO + 8'(2 * ch));
      assign cap_wr_hi = wr_i && (addr_i == OFF_CAP0_HI + 8'(2 * ch));

      // A software byte write lands after the capture of the same cycle.
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            capture_reg[ch] <= RESET_COUNT;
         end else begin
            if (capture_event_i[ch]) begin
               capture_reg[ch] <= count_value;
            end
            if (cap_wr_lo) begin
               capture_reg[ch][7:0] <= wdata_i;
            end
            if (cap_wr_hi) begin
               capture_reg[ch][15:8] <= wdata_i;
            end
         end
      end

      // An event in the same cycle as a clear leaves the flag set.
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            capture_flag_o[ch] <= 1'b0;
         end else if (capture_event_i[ch]) begin
            capture_flag_o[ch] <= 1'b1;
         end else if (capture_flag_clr_i[ch]) begin
            capture_flag_o[ch] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= overflow_flag_reg && timer_irq_en_i && global_irq_en_i;
      end
   end

   assign control_view = {overflow_flag_reg, 4'h0, run_bit_reg, 1'b0, mode_select_bit_reg};

   // Unmapped addresses and the unused control bits read as zero.
   always_comb begin
      read_mux = READ_UNMAPPED;
      unique case (addr_i)
         OFF_CONTROL: read_mux = control_view;
         OFF_MODE: read_mux = mode_register_reg;
         OFF_RCMP_LO: read_mux = reload_compare_lo_reg;
         OFF_RCMP_HI: read_mux = reload_compare_hi_reg;
         OFF_COUNT_LO: read_mux = count_low_reg;
         OFF_COUNT_HI: read_mux = count_high_reg;
         OFF_CAP0_LO: read_mux = capture_reg[0][7:0];
         OFF_CAP0_HI: read_mux = capture_reg[0][15:8];
         OFF_CAP1_LO: read_mux = capture_reg[1][7:0];
         OFF_CAP1_HI: read_mux = capture_reg[1][15:8];
         OFF_CAP2_LO: read_mux = capture_reg[2][7:0];
         OFF_CAP2_HI: read_mux = capture_reg[2][15:8];
         default: read_mux = READ_UNMAPPED;
      endcase
   end

   // Read data stand for the one cycle after the strobe and are zero otherwise.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= READ_UNMAPPED;
      end else if (rd_i) begin
         rdata_o <= read_mux;
      end else begin
         rdata_o <= READ_UNMAPPED;
      end
   end

endmodule // timer_two

/* test/timer_two_assertions.sv */
`timescale 1ns/1ps
module timer_two_assertions (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [timer_two_pkg::ADDR_W-1:0] addr_i,
   input wire logic [timer_two_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [timer_two_pkg::DATA_W-1:0] rdata_o,
   input wire logic [2:0] capture_event_i,
   input wire logic [2:0] capture_flag_clr_i,
   input wire logic timer_irq_en_i,
   input wire logic global_irq_en_i,
   input wire logic irq_o,
   input wire logic [2:0] capture_flag_o
);
   import timer_two_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic ctl_wr = wr_i && addr_i == OFF_CONTROL;
   wire logic [2:0] keep_w = capture_flag_o & ~capture_flag_clr_i;
   wire logic [2:0] src_w = capture_flag_o | capture_event_i;
   wire logic [2:0] clr_w = capture_flag_clr_i & ~capture_event_i;
   property p_irq_gate; !(timer_irq_en_i && global_irq_en_i) |=> !irq_o; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
   property p_irq_hold;
      !ctl_wr ##1 (irq_o && timer_irq_en_i && global_irq_en_i && !ctl_wr) |=> irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("flag dropped by itself");
   property p_cap_set;
      capture_event_i != 3'b000 |=>
         (capture_flag_o & $past(capture_event_i)) == $past(capture_event_i);
   endproperty
   a_cap_set: assert property (p_cap_set) else $error("capture flag not set");
   property p_cap_keep;
      keep_w != 3'b000 |=> (capture_flag_o & $past(keep_w)) == $past(keep_w);
   endproperty
   a_cap_keep: assert property (p_cap_keep) else $error("capture flag lost");
   property p_cap_src; src_w != 3'b111 |=> (capture_flag_o & ~$past(src_w)) == 3'b000; endproperty
   a_cap_src: assert property (p_cap_src) else $error("capture flag without event");
   property p_cap_clr; clr_w != 3'b000 |=> (capture_flag_o & $past(clr_w)) == 3'b000; endproperty
   a_cap_clr: assert property (p_cap_clr) else $error("capture flag not cleared");
   property p_ctl_rsv;
      rd_i && addr_i == OFF_CONTROL |=> rdata_o[6:3] == 4'h0 && !rdata_o[1];
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control unused bits set");
   property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule // timer_two_assertions
bind timer_two timer_two_assertions u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .capture_event_i, .capture_flag_clr_i, .timer_irq_en_i, .global_irq_en_i, .irq_o,
   .capture_flag_o);

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import timer_two_pkg::*;
   logic clk_i, rst_n_i, wr_i, rd_i, timer_irq_en_i, global_irq_en_i, irq_o;
   logic [7:0] addr_i, wdata_i, rdata_o, d, e;
   logic [2:0] capture_event_i, capture_flag_clr_i, capture_flag_o;
   int n_fail, tests_run, cycles, i, r;
   timer_two dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .capture_event_i,
      .capture_flag_clr_i, .timer_irq_en_i, .global_irq_en_i, .irq_o, .capture_flag_o);
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic chk(input string s, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask
   task automatic ck_irq(input logic v);
      @(negedge clk_i);
      chk("irq", {7'h0, irq_o}, {7'h0, v});
   endtask
   initial begin
      rst_n_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      capture_event_i = 3'b000;
      capture_flag_clr_i = 3'b000;
      timer_irq_en_i = 1'b1;
      global_irq_en_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 7; i++) begin
         rd((i < 6) ? 8'(OFF_CONTROL + i) : 8'h00);
         chk("reset value", d, 8'h00);
      end
      $display("reset done");
      for (i = 0; i < 8; i++) begin
         r = (i == 0) ? 1 : ((i == 1) ? 4 : 1 << (i + 2));
         wr(OFF_MODE, {1'b0, 3'(i), 4'h0});
         wr(OFF_COUNT_LO, 8'h00);
         wr(OFF_CONTROL, 8'h04);
         repeat (3 * r) @(posedge clk_i);
         wr(OFF_CONTROL, 8'h00);
         rd(OFF_COUNT_LO);
         e = d;
         chk("ticks", d, (i == 0) ? 8'h05 : 8'h03);
         repeat (4) @(posedge clk_i);
         rd(OFF_COUNT_LO);
         chk("held count", d, e);
      end
      $display("prescaler done");
      wr(OFF_RCMP_LO, 8'hF0);
      wr(OFF_RCMP_HI, 8'hFF);
      for (i = 0; i < 2; i++) begin
         wr(OFF_MODE, {i[0], 7'h00});
         wr(OFF_COUNT_LO, 8'hFE);
         wr(OFF_COUNT_HI, 8'hFF);
         wr(OFF_CONTROL, 8'h04);
         repeat (6) @(posedge clk_i);
         ck_irq(1'b1);
         wr(OFF_CONTROL, 8'h80);
         rd(OFF_COUNT_HI);
         chk("after overflow", d, i[0] ? 8'hFF : 8'h00);
         repeat (10) @(posedge clk_i);
         ck_irq(1'b1);
         @(posedge clk_i);
         global_irq_en_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         ck_irq(1'b0);
         @(posedge clk_i);
         global_irq_en_i <= 1'b1;
         wr(OFF_CONTROL, 8'h00);
         repeat (2) @(posedge clk_i);
         ck_irq(1'b0);
      end
      $display("reload done");
      wr(OFF_RCMP_LO, 8'h10);
      wr(OFF_RCMP_HI, 8'h00);
      for (i = 0; i < 2; i++) begin
         wr(OFF_MODE, {5'h00, i[0], 2'b00});
         wr(OFF_COUNT_LO, 8'h00);
         wr(OFF_COUNT_HI, 8'h00);
         wr(OFF_CONTROL, 8'h05);
         repeat (40) @(posedge clk_i);
         wr(OFF_CONTROL, 8'h01);
         ck_irq(1'b1);
         rd(OFF_COUNT_LO);
         chk("match clear", {7'h0, d <= 8'h10}, {7'h0, i[0]});
      end
      $display("compare done");
      wr(OFF_RCMP_HI, 8'hAB);
      for (i = 0; i < 4; i++) begin
         wr(OFF_MODE, (i == 3) ? 8'hF9 : (8'hF0 | 8'(i + 1)));
         wr(OFF_COUNT_LO, 8'h00);
         wr(OFF_COUNT_HI, 8'h12);
         wr(OFF_CONTROL, 8'h04);
         capture_event_i <= 3'b001 << (i % 3);
         @(posedge clk_i);
         capture_event_i <= 3'b000;
         wr(OFF_CONTROL, 8'h00);
         rd(8'(OFF_CAP0_HI + 2 * (i % 3)));
         chk("captured", d, 8'h12);
         chk("flags", {5'h00, capture_flag_o}, {5'h00, 3'b001 << (i % 3)});
         rd(OFF_COUNT_HI);
         chk("event load", d, (i == 3) ? 8'h00 : 8'hAB);
         @(posedge clk_i);
         capture_flag_clr_i <= 3'b111;
         @(posedge clk_i);
         capture_flag_clr_i <= 3'b000;
      end
      $display("capture done");
      end_of_test();
   end
endmodule // testbench
